// File: verilog/trc_top.sv
// run control for four down-counting timers and configuration of timer zero
// assumes tick and event inputs are single-cycle strobes on i_clock; the trimming
// input is an asynchronous pin and is synchronised here
// software run-control writes win over automatic events of the same cycle
//
// Functional notes
// - low four bits of a run-control write mask which run bits change.
// - bits seven to four show live running state of timers three to zero.
// - masked run bit one starts its timer, zero stops it.
// - mask bits are write-only; bit 3 pairs bit 7 down to bit 0 with 4.
// - halt-on-receive set stops timer zero once four bits are received.
// - halt-on-receive is ignored while oscillator trimming is selected.
// - trigger mode 00 means no automatic start, 01 starts at transmission end.
// - modes 10 and 11 trim the oscillator, toggling run on rising pin edges.
// - reload-on-zero set reloads the counter and keeps counting at zero, except in trigger mode 10, which stops.
// - reload-on-zero clear counts down to zero then stops.
// - every underflow sets the timer underflow flag.
// - clock select 00 counts fast ticks, 01 counts slow ticks.
// - clock select 10 counts timer two underflows, 11 timer one underflows.
// - each start of timer zero loads its counter from the reload bytes; timers one to three load OTHER_RELOAD.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module trc_top
  import trc_pkg::*;
#(
  parameter logic [15:0] OTHER_RELOAD = TRC_OTHER_RELOAD
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // counting ticks and link events
  input  wire logic       i_tick_13m56,
  input  wire logic       i_tick_211k,
  input  wire logic       i_tx_end,
  input  wire logic       i_rx_first4,
  input  wire logic       i_lfo_pin,
  // outputs
  output logic      [3:0] o_underflow,
  output logic            o_irq
);

  localparam int N = TRC_NUM_TIMERS;

  trc_bus_req_type   req;
  trc_t0_config_type cfg_r;
  trc_t0_config_type cfg_nxt;
  logic [15:0]       reload_r;
  logic [15:0]       reload_nxt;
  logic [15:0]       cnt_r [N];
  logic [15:0]       cnt_nxt [N];
  logic [N-1:0]      run_r;
  logic [N-1:0]      run_nxt;
  logic [N-1:0]      uf_r;
  logic [N-1:0]      uf_nxt;
  logic [N-1:0]      status_r;
  logic [N-1:0]      status_nxt;
  logic [N-1:0]      mask_r;
  logic [N-1:0]      mask_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              lfo_meta_r, lfo_meta_nxt;
  logic              lfo_sync_r, lfo_sync_nxt;
  logic              lfo_prev_r, lfo_prev_nxt;
  logic [N-1:0]      at_zero;
  logic              t0_tx_start;
  logic              t0_rx_halt;
  logic              t0_lfo_toggle;
  logic              t0_no_pulse;
  logic              t0_restart;
  logic [N-1:0]      tick;
  logic              lfo_rise;
  logic              trimming;

  assign req = '{addr: i_addr, data: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit_wr(input trc_bus_req_type r, input logic [7:0] a);
    hit_wr = r.wr && (r.addr == a);
  endfunction

  // trimming pin: second and third stages are read by the edge detector
  always_comb begin
    lfo_meta_nxt = i_lfo_pin;
    lfo_sync_nxt = lfo_meta_r;
    lfo_prev_nxt = lfo_sync_r;
  end

  // reset level low matches an idle pin, so no false edge follows reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lfo_meta_r <= 1'b0;
      lfo_sync_r <= 1'b0;
      lfo_prev_r <= 1'b0;
    end else begin
      lfo_meta_r <= lfo_meta_nxt;
      lfo_sync_r <= lfo_sync_nxt;
      lfo_prev_r <= lfo_prev_nxt;
    end
  end

  assign lfo_rise = lfo_sync_r && !lfo_prev_r;
  assign trimming = cfg_r.trigger_mode[1];

  // zero detect per counter
  generate
    for (genvar z = 0; z < N; z++) begin : g_zero
      assign at_zero[z] = (cnt_r[z] == 16'h0000);
    end
  endgenerate

  // timer zero event decode
  always_comb begin
    t0_tx_start   = (cfg_r.trigger_mode == TRC_START_TX_END) && i_tx_end;
    t0_lfo_toggle = trimming && lfo_rise;
    // halt-on-receive has no effect while trimming
    t0_rx_halt    = cfg_r.halt_on_receive && !trimming && i_rx_first4;
    // trimming without underflow stops quietly at zero
    t0_no_pulse   = (cfg_r.trigger_mode == TRC_START_LFO);
    t0_restart    = cfg_r.reload_on_zero && !t0_no_pulse;
  end

  // counting clock per timer; cascades use registered pulses so no loop forms
  always_comb begin
    // timers one to three always count fast ticks
    tick = {N{i_tick_13m56}};
    case (cfg_r.clock_select)
      TRC_CLK_13M56:     tick[0] = i_tick_13m56;
      TRC_CLK_211K:      tick[0] = i_tick_211k;
      TRC_CLK_TIMER2_UF: tick[0] = uf_r[2];
      TRC_CLK_TIMER1_UF: tick[0] = uf_r[1];
      default:           tick[0] = 1'b0;
    endcase
  end

  // configuration and reload registers
  always_comb begin
    cfg_nxt    = cfg_r;
    reload_nxt = reload_r;
    mask_nxt   = mask_r;
    if (hit_wr(req, TRC_ADDR_T0_CONFIG)) begin
      cfg_nxt      = trc_t0_config_type'(req.data);
      cfg_nxt.rsv6 = 1'b0;
      cfg_nxt.rsv2 = 1'b0;
    end
    if (hit_wr(req, TRC_ADDR_T0_RELOAD_H)) begin
      reload_nxt[15:8] = req.data;
    end
    if (hit_wr(req, TRC_ADDR_T0_RELOAD_L)) begin
      reload_nxt[7:0] = req.data;
    end
    if (hit_wr(req, TRC_ADDR_IRQ_MASK)) begin
      mask_nxt = req.data[N-1:0];
    end
  end

  // timer run state and counters
  always_comb begin
    logic [15:0] load_val;
    load_val = 16'h0000;
    run_nxt  = run_r;
    uf_nxt   = '0;
    for (int i = 0; i < N; i++) begin
      cnt_nxt[i] = cnt_r[i];
    end
    for (int i = 0; i < N; i++) begin
      load_val = (i == 0) ? reload_r : OTHER_RELOAD;
      if (run_r[i] && tick[i]) begin
        if (!at_zero[i]) begin
          cnt_nxt[i] = cnt_r[i] - 16'h0001;
        end else begin
          // trimming without underflow stops at zero with no pulse
          if (!(i == 0 && t0_no_pulse)) begin
            uf_nxt[i] = 1'b1;
          end
          if (i == 0 && t0_restart) begin
            cnt_nxt[i] = load_val;
          end else begin
            run_nxt[i] = 1'b0;
          end
        end
      end
      if (i == 0) begin
        if (t0_tx_start) begin
          run_nxt[0] = 1'b1;
          cnt_nxt[0] = load_val;
        end
        if (t0_lfo_toggle) begin
          run_nxt[0] = !run_r[0];
          if (!run_r[0]) begin
            cnt_nxt[0] = load_val;
          end
        end
        if (t0_rx_halt) begin
          run_nxt[0] = 1'b0;
        end
      end
      // software start or stop wins over the automatic events of the same cycle
      if (hit_wr(req, TRC_ADDR_RUN_CONTROL) && req.data[TRC_MASK_LSB + i]) begin
        run_nxt[i] = req.data[TRC_RUN_LSB + i];
        if (req.data[TRC_RUN_LSB + i]) begin
          cnt_nxt[i] = load_val;
        end
      end
    end
  end

  // sticky underflow flags: a new underflow beats a write-one clear
  always_comb begin
    status_nxt = status_r;
    if (hit_wr(req, TRC_ADDR_IRQ_STATUS)) begin
      status_nxt = status_r & ~req.data[N-1:0];
    end
    status_nxt = status_nxt | uf_nxt;
  end

  // read data, registered; counter bytes are live and not latched as a pair,
  // so a read during counting may tear between the two bytes
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      case (req.addr)
        TRC_ADDR_RUN_CONTROL: rdata_nxt = {run_r, 4'h0};
        TRC_ADDR_T0_CONFIG:   rdata_nxt = cfg_r;
        TRC_ADDR_T0_RELOAD_H: rdata_nxt = reload_r[15:8];
        TRC_ADDR_T0_RELOAD_L: rdata_nxt = reload_r[7:0];
        TRC_ADDR_T0_COUNT_H:  rdata_nxt = cnt_r[0][15:8];
        TRC_ADDR_T0_COUNT_L:  rdata_nxt = cnt_r[0][7:0];
        TRC_ADDR_IRQ_STATUS:  rdata_nxt = {4'h0, status_r};
        TRC_ADDR_IRQ_MASK:    rdata_nxt = {4'h0, mask_r};
        default:              rdata_nxt = 8'h00;
      endcase
    end
  end

  // configuration group
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cfg_r    <= trc_t0_config_type'(TRC_T0_CONFIG_RST);
      reload_r <= TRC_RELOAD_RST;
      mask_r   <= TRC_IRQ_MASK_RST;
    end else begin
      cfg_r    <= cfg_nxt;
      reload_r <= reload_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // run state and underflow pulses
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_r <= '0;
      uf_r  <= '0;
    end else begin
      run_r <= run_nxt;
      uf_r  <= uf_nxt;
    end
  end

  // sticky underflow flags
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // one register per counter
  generate
    for (genvar g = 0; g < N; g++) begin : g_cnt
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          cnt_r[g] <= TRC_RELOAD_RST;
        end else begin
          cnt_r[g] <= cnt_nxt[g];
        end
      end
    end
  endgenerate

  // interrupt level follows unmasked status; a new underflow beats a clear
  assign o_rdata     = rdata_r;
  assign o_underflow = uf_r;
  assign o_irq       = |(status_r & mask_r);

endmodule // trc_top

// File: verilog/trc_pkg.sv
// package for the timer run-control block: register offsets, field layouts, reset values
// assumes an 8-bit register port and tick strobes made on the same clock
package trc_pkg;

  // register offsets
  localparam logic [7:0] TRC_ADDR_RUN_CONTROL = 8'h0e;
  localparam logic [7:0] TRC_ADDR_T0_CONFIG   = 8'h0f;
  localparam logic [7:0] TRC_ADDR_T0_RELOAD_H = 8'h10;
  localparam logic [7:0] TRC_ADDR_T0_RELOAD_L = 8'h11;
  localparam logic [7:0] TRC_ADDR_T0_COUNT_H  = 8'h12;
  localparam logic [7:0] TRC_ADDR_T0_COUNT_L  = 8'h13;
  localparam logic [7:0] TRC_ADDR_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] TRC_ADDR_IRQ_MASK    = 8'h21;

  // field positions in the run-control register
  localparam int TRC_RUN_LSB  = 4;
  localparam int TRC_MASK_LSB = 0;

  // reset values
  localparam logic [7:0]  TRC_T0_CONFIG_RST = 8'h00;
  localparam logic [15:0] TRC_RELOAD_RST    = 16'h0000;
  localparam logic [3:0]  TRC_IRQ_MASK_RST  = 4'h0;
  localparam logic [15:0] TRC_OTHER_RELOAD  = 16'h00ff;

  // number of timers
  localparam int TRC_NUM_TIMERS = 4;

  // start trigger modes of timer zero
  localparam logic [1:0] TRC_START_MANUAL  = 2'h0;
  localparam logic [1:0] TRC_START_TX_END  = 2'h1;
  localparam logic [1:0] TRC_START_LFO     = 2'h2;
  localparam logic [1:0] TRC_START_LFO_UF  = 2'h3;

  // counting clock choices of timer zero
  localparam logic [1:0] TRC_CLK_13M56     = 2'h0;
  localparam logic [1:0] TRC_CLK_211K      = 2'h1;
  localparam logic [1:0] TRC_CLK_TIMER2_UF = 2'h2;
  localparam logic [1:0] TRC_CLK_TIMER1_UF = 2'h3;

  // timer zero configuration, laid out as the register bits 7..0
  typedef struct packed {
    logic       halt_on_receive;
    logic       rsv6;
    logic [1:0] trigger_mode;
    logic       reload_on_zero;
    logic       rsv2;
    logic [1:0] clock_select;
  } trc_t0_config_type;

  // register read and write request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } trc_bus_req_type;

endpackage

// File: verification/trc_checker.sv
// port-level assertions for the timer run-control block
// assumes the bench leaves a one-cycle gap between register strobes
`timescale 1ns/1ps
module trc_checker #(
  parameter logic [15:0] OTHER_RELOAD = 16'h00ff
) (
  // clock, reset, register port
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // events and outputs
  input wire logic       i_tick_13m56,
  input wire logic       i_tick_211k,
  input wire logic       i_tx_end,
  input wire logic       i_rx_first4,
  input wire logic       i_lfo_pin,
  input wire logic [3:0] o_underflow,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic wr_run = i_wr && i_addr == 8'h0e;
  wire logic rd_run = i_rd && i_addr == 8'h0e;
  // a start needs more ticks than the gap spans
  wire logic slow   = OTHER_RELOAD > 16'h0001;

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  mask_read_a: assert property ($past(rd_run) |-> o_rdata[3:0] == 4'h0)
    else $error("write mask bits read back");
  rsv_read_a: assert property ($past(i_rd) && $past(i_addr) == 8'h0f |->
    {o_rdata[6], o_rdata[2]} == 2'h0) else $error("reserved bits not zero");
  stop_read_a: assert property (wr_run ##2 rd_run |=>
    (o_rdata[7:5] & $past(i_wdata[3:1], 3) & ~$past(i_wdata[7:5], 3)) == 3'h0)
    else $error("stopped timer reads running");
  start_read_a: assert property (slow && wr_run ##2 rd_run |=>
    (~o_rdata[7:5] & $past(i_wdata[3:1], 3) & $past(i_wdata[7:5], 3)) == 3'h0)
    else $error("started timer reads idle");
  uf_pulse_a: assert property (o_underflow[3:1] != 3'h0 |=>
    (o_underflow[3:1] & $past(o_underflow[3:1])) == 3'h0) else $error("pulse too long");
  uf_tick_a: assert property (o_underflow[3:1] != 3'h0 |-> $past(i_tick_13m56))
    else $error("underflow without a tick");
  irq_mask_a: assert property (i_wr && i_addr == 8'h21 && i_wdata[3:0] == 4'h0 |=> !o_irq)
    else $error("masked interrupt still high");
  cover property (o_underflow[0]);
  cover property (o_irq);
  cover property ($past(rd_run) && o_rdata[4]);
endmodule // trc_checker

// File: verification/trc_top_test.sv
// self-checking bench for trc_top: register tasks and event pulses
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/1ps
module trc_top_test;
  logic       i_clock, i_rst, i_wr, i_rd, i_lfo_pin, o_irq;
  logic [7:0] i_addr, i_wdata, o_rdata;
  // events: receive, transmit end, slow tick, fast tick
  logic [3:0] ev, o_underflow;
  int         failures, total_checks, cyc, uf0;
  logic [7:0] cfg[3] = '{8'h00, 8'h10, 8'h90};
  logic [7:0] ex_tx[3] = '{8'h00, 8'h10, 8'h10};
  logic [7:0] ex_rx[3] = '{8'h00, 8'h10, 8'h00};
  logic [7:0] runw[4] = '{8'hf0, 8'hc4, 8'hff, 8'h0f};
  logic [7:0] rune[4] = '{8'h00, 8'h40, 8'hf0, 8'h00};

  trc_top #(.OTHER_RELOAD(16'h0003)) trc_top_inst (
    .i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tick_13m56(ev[0]), .i_tick_211k(ev[1]), .i_tx_end(ev[2]), .i_rx_first4(ev[3]),
    .i_lfo_pin, .o_underflow, .o_irq);

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // the run needs about 200 cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_underflow[0] === 1'b1) uf0 <= uf0 + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, o_rdata);
    @(posedge i_clock);
  endtask
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      ev <= m;
      @(posedge i_clock);
      ev <= 4'h0;
      @(posedge i_clock);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {i_rst, i_wr, i_rd, i_lfo_pin, i_addr, i_wdata, ev} = {1'b1, 23'h0};
    {failures, total_checks, cyc, uf0} = '0;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h0f, 8'h00);
    rd(8'h30, 8'h00);
    foreach (runw[k]) begin
      wr(8'h0e, runw[k]);
      rd(8'h0e, rune[k]);
    end
    wr(8'h11, 8'h02);
    wr(8'h21, 8'h01);
    wr(8'h0e, 8'h11);
    rd(8'h13, 8'h02);
    wr(8'h11, 8'h07);
    pulse(4'h1, 2);
    rd(8'h13, 8'h00);
    pulse(4'h1, 1);
    rd(8'h0e, 8'h00);
    rd(8'h20, 8'h01);
    chk("irq", 8'h01, {7'h0, o_irq});
    wr(8'h21, 8'h00);
    chk("irq", 8'h00, {7'h0, o_irq});
    wr(8'h21, 8'h01);
    chk("pulses", 8'h01, uf0[7:0]);
    wr(8'h20, 8'h01);
    chk("irq", 8'h00, {7'h0, o_irq});
    wr(8'h11, 8'h02);
    wr(8'h0f, 8'h09);
    wr(8'h0e, 8'h11);
    pulse(4'h1, 2);
    rd(8'h13, 8'h02);
    pulse(4'h2, 3);
    rd(8'h0e, 8'h10);
    rd(8'h13, 8'h02);
    wr(8'h0e, 8'h01);
    foreach (cfg[k]) begin
      wr(8'h0f, cfg[k]);
      pulse(4'h4, 1);
      rd(8'h0e, ex_tx[k]);
      pulse(4'h8, 1);
      rd(8'h0e, ex_rx[k]);
      wr(8'h0e, 8'h01);
    end
    wr(8'h0f, 8'ha0);
    i_lfo_pin <= 1'b1;
    pulse(4'h8, 3);
    rd(8'h0e, 8'h10);
    i_lfo_pin <= 1'b0;
    pulse(4'h0, 3);
    i_lfo_pin <= 1'b1;
    pulse(4'h0, 3);
    rd(8'h0e, 8'h00);
    wr(8'h20, 8'h01);
    wr(8'h0f, 8'h31);
    i_lfo_pin <= 1'b0;
    pulse(4'h0, 3);
    i_lfo_pin <= 1'b1;
    pulse(4'h0, 3);
    pulse(4'h2, 3);
    rd(8'h20, 8'h01);
    wr(8'h11, 8'h00);
    wr(8'h20, 8'h0f);
    for (int k = 0; k < 2; k++) begin
      wr(8'h0f, k ? 8'h03 : 8'h02);
      wr(8'h0e, k ? 8'h33 : 8'h55);
      pulse(4'h1, 4);
      rd(8'h20, k ? 8'h03 : 8'h05);
      wr(8'h20, 8'h0f);
    end
    results();
  end
endmodule // trc_top_test

bind trc_top trc_checker #(.OTHER_RELOAD(OTHER_RELOAD)) trc_checker_inst (
  .i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tick_13m56,
  .i_tick_211k, .i_tx_end, .i_rx_first4, .i_lfo_pin, .o_underflow, .o_irq);
